/* File: verilog/lpmc_top.sv */
`timescale 1ns/10ps
`include "lpmc_regs.svh"
// Summary of operation
// [R01] wfi enters wait when deep sleep select clear, stop when set
// [R02] normal run and very low power run each own their wait and stop
// [R03] pin level and direction held unchanged in every low power mode
// [R04] normal wait gates core clock only; interrupt returns to run
// [R05] normal stop freezes logic, keeps registers and voltage detect
// [R06] bus alive partial stop gates core and system clocks, bus runs
// [R07] bus alive partial stop keeps bus masters and slaves running
// [R08] bus gated partial stop gates all clocks, bus parties stop
// [R09] partial stops keep clock generator and regulator in run modes
// [R10] very low power run: 1MHz flash, low power regulator, detect off
// [R11] very low power run may select internal 4 MHz oscillator
// [R12] very low power run or wait disable biasing with continuous dcdc
// [R13] very low power run allows radio only with continuous dcdc
// [R14] very low power wait keeps run settings and gates core clock
// [R15] normal run permits radio with full performance clocks
// [R16] interrupt wake returns to entry run mode, clocks before core
module lpmc_top
   import lpmc_pkg::*;
(
   input wire logic core_clk_in, // system clock
   input wire logic sys_rst_in, // synchronous reset, high
   input wire logic clk_en_in, // freezes all state when low
   input wire logic [`LPMC_ADDR_W-1:0] avs_address_in, // byte address
   input wire logic avs_read_in, // read request
   input wire logic avs_write_in, // write request
   input wire logic [31:0] avs_writedata_in, // write data
   output logic [31:0] avs_readdata_out, // read data
   output logic avs_waitrequest_out, // stall
   input wire logic wait_for_interrupt_instr_in, // core sleep pulse
   input wire logic deep_sleep_select_in, // core deep sleep bit
   input wire logic irq_in, // pending interrupt level
   output logic core_clk_en_out, // core clock gate enable
   output logic sys_clk_en_out, // system clock gate enable
   output logic bus_clk_en_out, // bus clock gate enable
   output logic bus_stop_req_out, // bus masters/slaves stop
   output logic static_freeze_out, // logic held static
   output logic low_voltage_detect_en_out, // voltage detector on
   output logic reg_low_power_out, // regulator low power
   output logic clkgen_run_out, // clock generator kept running
   output logic flash_tick_out, // flash access enable
   output logic int_osc_sel_out, // internal 4 MHz source for core
   output logic bias_en_out, // biasing enabled
   output logic radio_en_out, // radio permitted
   output logic [`LPMC_PIN_W-1:0] pin_level_out, // held pin levels
   output logic [`LPMC_PIN_W-1:0] pin_dir_out, // held pin directions
   output logic [2:0] state_out, // current power state
   output logic vlp_out // very low power run family
);
   // ---------------------------------------------
   // declarations
   // ---------------------------------------------
   lpmc_state_e state;
   lpmc_state_e next_state;
   logic vlp; // active run mode family
   logic [4:0] ctrl;
   logic [`LPMC_DIV_W-1:0] flash_div;
   logic bus_req;
   logic bus_done;
   logic ctrl_vlp;
   logic [1:0] ctrl_stopsel;
   logic ctrl_dcdc_cont;
   logic awake;

   // control field extraction
   assign ctrl_vlp = ctrl[`LPMC_CTRL_VLP_BIT];
   assign ctrl_stopsel = ctrl[`LPMC_CTRL_STOPSEL_HI:`LPMC_CTRL_STOPSEL_LO];
   assign ctrl_dcdc_cont = ctrl[`LPMC_CTRL_DCDC_CONT_BIT];
   assign bus_req = avs_read_in | avs_write_in;
   assign bus_done = bus_req & ~avs_waitrequest_out;
   assign awake = (state == LPMC_ST_RUN);

   // ---------------------------------------------
   // helper functions
   // ---------------------------------------------
   // stop variant chosen for a deep sleep request
   function automatic lpmc_state_e stop_target(input logic [1:0] sel);
      lpmc_state_e t;
      t = LPMC_ST_STOP;
      if (sel == `LPMC_STOPSEL_BUS_ALIVE) begin
         t = LPMC_ST_PSTOP_BUS_ALIVE;
      end else if (sel == `LPMC_STOPSEL_BUS_GATED) begin
         t = LPMC_ST_PSTOP_BUS_GATED;
      end
      return t;
   endfunction : stop_target

   // register read mux
   function automatic logic [31:0] read_mux(input logic [`LPMC_ADDR_W-1:0] a);
      logic [31:0] d;
      d = 32'h00000000;
      if (a == `LPMC_OFS_CTRL) begin
         d = {27'h0000000, ctrl};
      end else if (a == `LPMC_OFS_STATUS) begin
         d = {24'h000000, radio_en_out, bias_en_out, low_voltage_detect_en_out,
              vlp, 1'b0, state};
      end else if (a == `LPMC_OFS_PINS) begin
         d = {16'h0000, pin_dir_out, pin_level_out};
      end
      return d;
   endfunction : read_mux

   // ---------------------------------------------
   // power state machine
   // ---------------------------------------------
   // next state from sleep requests and interrupts
   always_comb begin
      next_state = state;
      case (state)
         LPMC_ST_RUN: begin
            if (wait_for_interrupt_instr_in) begin
               if (deep_sleep_select_in) begin
                  next_state = stop_target(ctrl_stopsel); // R01
               end else begin
                  next_state = LPMC_ST_WAIT; // R01
               end
            end
         end
         LPMC_ST_WAIT, LPMC_ST_STOP, LPMC_ST_PSTOP_BUS_ALIVE,
         LPMC_ST_PSTOP_BUS_GATED: begin
            if (irq_in) begin
               next_state = LPMC_ST_WAKE; // R16
            end
         end
         LPMC_ST_WAKE: begin
            next_state = LPMC_ST_RUN; // R16
         end
         default: begin
            next_state = LPMC_ST_RUN;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state <= LPMC_ST_RUN;
      end else if (clk_en_in) begin
         state <= next_state;
      end
   end

   // run family switches only while awake, so wait/stop return to it
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         vlp <= 1'b0;
      end else if (clk_en_in && awake && next_state == LPMC_ST_RUN) begin
         vlp <= ctrl_vlp; // R02
      end
   end

   // ---------------------------------------------
   // clock gates and power controls
   // ---------------------------------------------
   // gates follow the next state so they change with the state
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         core_clk_en_out <= 1'b1;
         sys_clk_en_out <= 1'b1;
         bus_clk_en_out <= 1'b1;
         bus_stop_req_out <= 1'b0;
         static_freeze_out <= 1'b0;
         clkgen_run_out <= 1'b1;
      end else if (clk_en_in) begin
         core_clk_en_out <= (next_state == LPMC_ST_RUN); // R04 R14 R16
         sys_clk_en_out <= (next_state == LPMC_ST_RUN) ||
                           (next_state == LPMC_ST_WAIT) ||
                           (next_state == LPMC_ST_WAKE); // R06 R16
         bus_clk_en_out <= (next_state != LPMC_ST_STOP) &&
                           (next_state != LPMC_ST_PSTOP_BUS_GATED); // R07 R08
         bus_stop_req_out <= (next_state == LPMC_ST_STOP) ||
                             (next_state == LPMC_ST_PSTOP_BUS_GATED); // R08
         static_freeze_out <= (next_state == LPMC_ST_STOP); // R05
         clkgen_run_out <= (next_state != LPMC_ST_STOP); // R09
      end
   end

   // regulator, detector and bias follow the run family; radio also needs the next state to be run
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         low_voltage_detect_en_out <= 1'b1;
         reg_low_power_out <= 1'b0;
         int_osc_sel_out <= 1'b0;
         bias_en_out <= 1'b1;
         radio_en_out <= 1'b1;
      end else if (clk_en_in) begin
         low_voltage_detect_en_out <= ~vlp; // R05 R10
         reg_low_power_out <= vlp; // R09 R10
         int_osc_sel_out <= vlp & ctrl[`LPMC_CTRL_INT_OSC_BIT]; // R11
         bias_en_out <= ~(vlp & ctrl_dcdc_cont); // R12 R14
         radio_en_out <= (next_state == LPMC_ST_RUN) &&
                         (~vlp || ctrl_dcdc_cont); // R13 R15
      end
   end

   // flash access slowed to 1MHz in very low power run
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         flash_div <= '0;
         flash_tick_out <= 1'b1;
      end else if (clk_en_in) begin
         if (!vlp || flash_div == `LPMC_DIV_W'(`LPMC_FLASH_DIV - 1)) begin
            flash_div <= '0;
         end else begin
            flash_div <= flash_div + `LPMC_DIV_W'(1);
         end
         flash_tick_out <= ~vlp || (flash_div == '0); // R10
      end
   end

   // ---------------------------------------------
   // avalon slave and registers
   // ---------------------------------------------
   // one stall cycle per request, then a one-cycle answer
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h00000000;
      end else if (clk_en_in) begin
         if (bus_req && avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= read_mux(avs_address_in);
         end else begin
            avs_waitrequest_out <= 1'b1;
         end
      end
   end

   // control register
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ctrl <= `LPMC_CTRL_RESET;
      end else if (clk_en_in && bus_done && avs_write_in &&
                   avs_address_in == `LPMC_OFS_CTRL) begin
         ctrl <= avs_writedata_in[4:0];
      end
   end

   // pin states change only while awake in a run mode
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         {pin_dir_out, pin_level_out} <= `LPMC_PINS_RESET;
      end else if (clk_en_in && awake && bus_done && avs_write_in &&
                   avs_address_in == `LPMC_OFS_PINS) begin
         {pin_dir_out, pin_level_out} <= avs_writedata_in[15:0]; // R03
      end
   end

   // status mirrors
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state_out <= 3'h0;
         vlp_out <= 1'b0;
      end else if (clk_en_in) begin
         state_out <= next_state;
         vlp_out <= vlp;
      end
   end

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in || !clk_en_in);

   sequence s_low_wake;
      (state != LPMC_ST_RUN) && (state != LPMC_ST_WAKE) && irq_in;
   endsequence
   sequence s_clocks_then_core;
      (state == LPMC_ST_WAKE) && sys_clk_en_out && !core_clk_en_out
      ##1 (state == LPMC_ST_RUN) && core_clk_en_out;
   endsequence

   a_wfi_wait_entry: assert property (awake && wait_for_interrupt_instr_in &&
      !deep_sleep_select_in |=> state == LPMC_ST_WAIT && !core_clk_en_out &&
      sys_clk_en_out && bus_clk_en_out) // R01
      else $error("wait not entered on shallow sleep");
   a_wfi_stop_entry: assert property (awake && wait_for_interrupt_instr_in &&
      deep_sleep_select_in |=> state != LPMC_ST_WAIT && state != LPMC_ST_RUN) // R01
      else $error("stop not entered on deep sleep");
   a_wake_order: assert property (s_low_wake |=> s_clocks_then_core) // R16
      else $error("wake did not restore clocks before core");
   a_vlp_kept: assert property (!awake |=> $stable(vlp)) // R02
      else $error("run family changed while asleep");
   a_pin_hold: assert property (!awake |=> $stable(pin_level_out) &&
      $stable(pin_dir_out)) // R03
      else $error("pin state changed in low power mode");
   a_stop_static: assert property (state == LPMC_ST_STOP |-> static_freeze_out &&
      !sys_clk_en_out && !bus_clk_en_out && low_voltage_detect_en_out == !vlp) // R05
      else $error("normal stop not static");
   a_pstop_alive: assert property (state == LPMC_ST_PSTOP_BUS_ALIVE |->
      !core_clk_en_out && !sys_clk_en_out && bus_clk_en_out && !bus_stop_req_out &&
      clkgen_run_out) // R06
      else $error("bus alive partial stop gates wrong");
   a_pstop_gated: assert property (state == LPMC_ST_PSTOP_BUS_GATED |->
      !bus_clk_en_out && bus_stop_req_out && clkgen_run_out) // R08
      else $error("bus gated partial stop gates wrong");
   a_vlp_power: assert property ($past(vlp) |-> reg_low_power_out &&
      !low_voltage_detect_en_out) // R10
      else $error("very low power run settings missing");
   a_radio_gate: assert property (awake && vlp && !ctrl_dcdc_cont &&
      $stable(ctrl) |=> !radio_en_out) // R13
      else $error("radio allowed without continuous dcdc");
endmodule : lpmc_top

/* File: verilog/lpmc_regs.svh */
`ifndef LPMC_REGS_SVH
`define LPMC_REGS_SVH
// ---------------------------------------------
// register map (byte addresses)
// ---------------------------------------------
`define LPMC_ADDR_W 4
`define LPMC_OFS_CTRL 4'h0
`define LPMC_OFS_STATUS 4'h4
`define LPMC_OFS_PINS 4'h8
// ---------------------------------------------
// control field positions
// ---------------------------------------------
`define LPMC_CTRL_VLP_BIT 0
`define LPMC_CTRL_STOPSEL_LO 1
`define LPMC_CTRL_STOPSEL_HI 2
`define LPMC_CTRL_DCDC_CONT_BIT 3
`define LPMC_CTRL_INT_OSC_BIT 4
`define LPMC_CTRL_RESET 5'h00
// ---------------------------------------------
// stop variant selector codes
// ---------------------------------------------
`define LPMC_STOPSEL_NORMAL 2'h0
`define LPMC_STOPSEL_BUS_ALIVE 2'h1
`define LPMC_STOPSEL_BUS_GATED 2'h2
// ---------------------------------------------
// pin hold register and timing
// ---------------------------------------------
`define LPMC_PIN_W 8
`define LPMC_PINS_RESET 16'h0000
`define LPMC_CLK_HZ 100000000
`define LPMC_FLASH_SLOW_HZ 1000000
`define LPMC_FLASH_DIV (`LPMC_CLK_HZ / `LPMC_FLASH_SLOW_HZ)
`define LPMC_DIV_W 7
`endif

/* File: verilog/lpmc_pkg.sv */
package lpmc_pkg;
   typedef enum logic [2:0] {
      LPMC_ST_RUN,
      LPMC_ST_WAIT,
      LPMC_ST_STOP,
      LPMC_ST_PSTOP_BUS_ALIVE,
      LPMC_ST_PSTOP_BUS_GATED,
      LPMC_ST_WAKE
   } lpmc_state_e;
endpackage : lpmc_pkg

/* File: verification/lpmc_core_model.sv */
`timescale 1ns/10ps
// ---------------------------------------------
// core side: sleep pulses and interrupt wake
// ---------------------------------------------
module lpmc_core_model (
   input wire logic clk_in, // system clock
   input wire logic core_clk_en_in, // core clock gate from controller
   output logic wfi_out, // sleep instruction pulse
   output logic deep_out, // deep sleep select level
   output logic irq_out // interrupt level
);
   // idle at time zero
   initial begin
      wfi_out = 1'b0;
      deep_out = 1'b0;
      irq_out = 1'b0;
   end
   // one-cycle pulse with deep select beside it, then let the edge land
   task automatic sleep(input logic d);
      @(posedge clk_in);
      wfi_out <= 1'b1;
      deep_out <= d;
      @(posedge clk_in);
      wfi_out <= 1'b0;
      #1;
   endtask : sleep
   // hold the interrupt until the core clock is back, report cycles taken
   task automatic wake(output int n);
      n = 0;
      @(posedge clk_in);
      irq_out <= 1'b1;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (core_clk_en_in !== 1'b1 && n < 50);
      @(posedge clk_in);
      irq_out <= 1'b0;
      #1;
   endtask : wake
endmodule : lpmc_core_model

/* File: verification/lpmc_top_test.sv */
`timescale 1ns/10ps
`include "lpmc_regs.svh"
// ---------------------------------------------
// bench for the power mode controller
// ---------------------------------------------
module lpmc_top_test
   import lpmc_pkg::*;
;
   logic clk, rst, cen, rd, wr, wreq, wait_for_interrupt_instr, deep, irq, vlp, ftick, osc, bias;
   logic core_en, sys_en, bus_en, bstop, frz, low_voltage_detect, reglp, cgen, radio;
   logic [3:0] adr;
   logic [31:0] wd, rdat, q;
   logic [7:0] plev, pdir;
   logic [2:0] st;
   logic [8:0] gates;
   int err_total, n_tests, cyc, n;
   // gate and mode outputs seen as one vector
   assign gates = {core_en, sys_en, bus_en, bstop, frz, low_voltage_detect, reglp, cgen, radio};
   lpmc_top i_dut (.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(cen),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
      .wait_for_interrupt_instr_in(wait_for_interrupt_instr), .deep_sleep_select_in(deep), .irq_in(irq),
      .core_clk_en_out(core_en), .sys_clk_en_out(sys_en), .bus_clk_en_out(bus_en),
      .bus_stop_req_out(bstop), .static_freeze_out(frz), .low_voltage_detect_en_out(low_voltage_detect),
      .reg_low_power_out(reglp), .clkgen_run_out(cgen), .flash_tick_out(ftick),
      .int_osc_sel_out(osc), .bias_en_out(bias), .radio_en_out(radio),
      .pin_level_out(plev), .pin_dir_out(pdir), .state_out(st), .vlp_out(vlp));
   lpmc_core_model i_core (.clk_in(clk), .core_clk_en_in(core_en), .wfi_out(wait_for_interrupt_instr),
      .deep_out(deep), .irq_out(irq));
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out;
      end
   end
   task automatic close_out;
      if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one bus access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      adr <= a;
      wd <= d;
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task automatic ticks(input int exp);
      int c;
      c = 0;
      repeat (100) begin
         @(posedge clk);
         #1;
         c += ftick;
      end
      chk(c, exp);
   endtask : ticks
   task automatic t_reset;
      #1 chk(gates, 9'h1CB);
      bus(1'b0, `LPMC_OFS_STATUS, 0);
      chk(q, 32'hE0);
      ticks(100);
   endtask : t_reset
   task automatic t_wait;
      i_core.sleep(1'b0);
      chk(st, LPMC_ST_WAIT);
      chk(gates, 9'h0CA);
      i_core.wake(n);
      chk(n, 2);
      chk(gates, 9'h1CB);
   endtask : t_wait
   // every stop selector code, with registers kept across the stop
   task automatic t_stops;
      logic [2:0] es [4] = '{LPMC_ST_STOP, LPMC_ST_PSTOP_BUS_ALIVE,
         LPMC_ST_PSTOP_BUS_GATED, LPMC_ST_STOP};
      logic [8:0] eg [4] = '{9'h038, 9'h04A, 9'h02A, 9'h038};
      logic [8:0] em [4] = '{9'h1FF, 9'h1FF, 9'h1FF, 9'h1FF};
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, `LPMC_OFS_CTRL, s << 1);
         i_core.sleep(1'b1);
         chk(st, es[s]);
         chk(gates & em[s], eg[s]);
         i_core.wake(n);
         chk(n, 2);
         bus(1'b0, `LPMC_OFS_CTRL, 0);
         chk(q, s << 1);
      end
   endtask : t_stops
   task automatic t_vlp;
      bus(1'b1, `LPMC_OFS_CTRL, 32'h19);
      settle;
      chk(gates, 9'h1C7);
      chk({osc, bias, vlp}, 3'b101);
      ticks(1);
      i_core.sleep(1'b0);
      chk({st, gates}, {LPMC_ST_WAIT, 9'h0C6});
      chk({bias, vlp}, 2'b01);
      i_core.wake(n);
      chk({n[3:0], vlp, core_en}, 6'h0B);
      i_core.sleep(1'b1);
      chk({st, vlp, low_voltage_detect}, {LPMC_ST_STOP, 2'b10});
      i_core.wake(n);
      bus(1'b1, `LPMC_OFS_CTRL, 32'h01);
      settle;
      chk(gates, 9'h1C6);
      chk({osc, bias}, 2'b01);
      bus(1'b1, `LPMC_OFS_CTRL, 0);
      settle;
      chk(gates, 9'h1CB);
   endtask : t_vlp
   // pin hold across wait, refused and unmapped accesses
   task automatic t_pins;
      bus(1'b1, `LPMC_OFS_PINS, 32'hA55A);
      settle;
      chk({pdir, plev}, 16'hA55A);
      i_core.sleep(1'b0);
      bus(1'b1, `LPMC_OFS_PINS, 32'h1234);
      settle;
      chk({pdir, plev}, 16'hA55A);
      bus(1'b0, `LPMC_OFS_STATUS, 0);
      chk(q, 32'h61);
      i_core.wake(n);
      chk({pdir, plev}, 16'hA55A);
      bus(1'b0, 4'hC, 0);
      chk(q, 32'h0);
      bus(1'b1, `LPMC_OFS_STATUS, 32'hFF);
      bus(1'b0, `LPMC_OFS_STATUS, 0);
      chk(q, 32'hE0);
   endtask : t_pins
   // clock enable low: a sleep pulse is lost and the state and the gate and mode vector hold
   task automatic t_freeze;
      @(posedge clk);
      cen <= 1'b0;
      i_core.sleep(1'b0);
      settle;
      chk({st, gates}, {LPMC_ST_RUN, 9'h1CB});
      @(posedge clk);
      cen <= 1'b1;
      settle;
      chk({st, gates}, {LPMC_ST_RUN, 9'h1CB});
   endtask : t_freeze
   // main sequence
   initial begin
      err_total = 0;
      n_tests = 0;
      cyc = 0;
      rst = 1'b1;
      cen = 1'b1;
      rd = 1'b0;
      wr = 1'b0;
      adr = 4'h0;
      wd = 32'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_wait;
      t_stops;
      t_vlp;
      t_pins;
      t_freeze;
      close_out;
   end
endmodule : lpmc_top_test
